/* sct_seq.sv */
// conversion sequencer: paces a channel list from a timer or an external clock,
// gated by a hardware trigger, with an AXI4-Lite register file
// assumes external pins are asynchronous and the converter answers on ADC
`timescale 1ns/1ns
module sct_seq import sct_pkg::*; #(
  parameter int LIST_DEPTH = 16
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic EXT_CLK_IN,
  input wire logic SYNC_CLK_IN,
  output logic SYNC_CLK_OUT,
  input wire logic TRIG_IN,
  input wire logic EXT_CLK_OUT,
  input wire logic TRIG_OUT,
  output logic OUT_UPDATE,
  output sct_conv_t CONV,
  input wire sct_adc_t ADC
);
  localparam int IW = $clog2(LIST_DEPTH);
  sct_state_t s, n;
  logic [7:0] mem_rd;
  logic mem_we;

  function automatic logic [15:0] gain_min(input logic [1:0] g);
    case (g)
      2'h0: gain_min = 16'(MIN_G1_CYC);
      2'h1: gain_min = 16'(MIN_G4_CYC);
      2'h2: gain_min = 16'(MIN_G10_CYC);
      default: gain_min = 16'(MIN_G40_CYC);
    endcase
  endfunction

  sct_chan_mem #(.DEPTH(LIST_DEPTH), .WIDTH(8)) u_mem (
    .clk(MCLK),
    .we(mem_we),
    .waddr(s.awaddr[IW+1:2]),
    .wdata(s.wdata[7:0]),
    .raddr(s.idx),
    .rdata(mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic wr_go, rd_go, pace_src, pace_edge, itick, otick, gate_hi, last;
  logic [15:0] iv;
  logic [23:0] need;
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb begin
    n = s;
    // two-stage synchronisers on every clock and trigger pin
    n.eclk_s = {s.eclk_s[0], EXT_CLK_IN};
    n.sclk_s = {s.sclk_s[0], SYNC_CLK_IN};
    n.trig_s = {s.trig_s[0], TRIG_IN};
    n.oclk_s = {s.oclk_s[0], EXT_CLK_OUT};
    n.otrig_s = {s.otrig_s[0], TRIG_OUT};
    // master paces from its own pin, slave from the shared clock
    // slave role takes the shared clock in
    pace_src = s.master ? s.eclk_s[1] : s.sclk_s[1];
    n.pace_d = pace_src;
    n.oclk_d = s.oclk_s[1];
    pace_edge = pace_src & ~s.pace_d;
    iv = (s.ival < 16'h0002) ? 16'h0002 : s.ival;
    last = ({1'b0, s.idx} + 5'h01) >= ((s.len == 5'h00) ? 5'h01 : s.len);
    gate_hi = s.trig_s[1];
    mem_we = 1'b0;

    // AXI write: address and data in either order, response after both
    n.awrdy = 1'b0;
    n.wrdy = 1'b0;
    if (S_AXI_AWVALID && s.awrdy) begin
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s.wrdy) begin
      n.w_got = 1'b1;
      n.wdata = S_AXI_WDATA;
    end
    wr_go = s.aw_got && s.w_got && !s.bvalid;
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (!n.aw_got && !n.bvalid) begin
      n.awrdy = !(S_AXI_AWVALID && s.awrdy);
    end
    if (!n.w_got && !n.bvalid) begin
      n.wrdy = !(S_AXI_WVALID && s.wrdy);
    end
    n.conv = 1'b0;
    n.sync_out = 1'b0;
    n.out_upd = 1'b0;
    if (wr_go) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OK;
      case (s.awaddr)
        A_CTRL: begin
          // list pacing held here, whole-list after reset
          n.list_pace = s.wdata[C_LIST];
          n.ext_sel = s.wdata[C_EXT];
          n.trig_mode = sct_trig_t'(s.wdata[C_TRIG+:2]);
          n.master = s.wdata[C_MASTER];
          n.out_en = s.wdata[C_OEN];
          n.out_ext = s.wdata[C_OEXT];
          n.out_trig = sct_trig_t'(s.wdata[C_OTRIG+:2]);
          n.gain = s.wdata[C_GAIN+:2];
        end
        A_IVAL: n.ival = s.wdata[15:0];
        A_LEN: n.len = s.wdata[4:0];
        A_COUNT: n.count_lim = s.wdata;
        A_OIVAL: n.oival = s.wdata[15:0];
        A_STAT: begin
          if (s.wdata[S_PERR]) begin
            n.perr = 1'b0;
          end
        end
        default: begin
          if (s.awaddr >= A_LIST && s.awaddr < A_LIST + 8'(4 * LIST_DEPTH)) begin
            mem_we = 1'b1;
          end else begin
            n.bresp = RESP_ERR;
          end
        end
      endcase
    end

    // AXI read
    rd_go = S_AXI_ARVALID && s.arrdy;
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      A_CTRL: rd_val = {19'h0, s.gain, s.out_trig, s.out_ext, s.out_en, s.master,
                        s.trig_mode, s.ext_sel, s.list_pace, 2'h0};
      A_IVAL: rd_val = {16'h0, s.ival};
      A_LEN: rd_val = {27'h0, s.len};
      A_COUNT: rd_val = s.count_lim;
      // interval below the gain minimum shows in the status word
      A_STAT: rd_val = {22'h0, (s.ival < gain_min(s.gain)), s.perr, s.st, 4'(s.idx)};
      // last sample is readable right after it lands
      A_SAMPLE: rd_val = {8'h0, s.sample_chan, s.sample};
      A_TAKEN: rd_val = s.taken;
      A_OIVAL: rd_val = {16'h0, s.oival};
      default: begin
        rd_val = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rdata = rd_val;
      n.rresp = rd_ok ? RESP_OK : RESP_ERR;
      n.arrdy = 1'b0;
    end else if (s.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
      n.arrdy = 1'b1;
    end else if (!s.rvalid) begin
      // ready comes up by itself after reset, otherwise no first read is ever taken
      n.arrdy = 1'b1;
    end

    // converter result captured on its valid cycle
    if (ADC.valid) begin
      n.sample = ADC.data;
      n.sample_chan = s.conv_chan;
    end

    // edge gap saturates, never times out
    if (pace_edge) begin
      n.gap = 16'h0001;
    end else if (s.gap != 16'hFFFF) begin
      n.gap = s.gap + 16'h0001;
    end
    // one margin constant for both pacing modes
    need = (s.list_pace ? 24'(iv * s.len) : 24'(iv)) + 24'(SYNC_MARGIN_CYC);
    // whole-list period checked single-channel period checked
    if (s.ext_sel && pace_edge && (s.st == ST_WAIT || s.st == ST_BURST)) begin
      if ({8'h0, s.gap} <= need || s.st == ST_BURST) begin
        n.perr = 1'b1;
      end
    end

    itick = (s.tmr == 16'h0000);
    if (s.st == ST_WAIT || s.st == ST_BURST) begin
      n.tmr = itick ? 16'(iv - 16'h0001) : 16'(s.tmr - 16'h0001);
    end

    case (s.st)
      ST_IDLE: begin
        n.idx = 4'h0;
      end
      ST_ARM: begin
        // dedicated trigger starts sampling nothing before it
        if (s.trig_mode == TRG_OFF || gate_hi) begin
          n.st = ST_WAIT;
          n.tmr = 16'h0000;
        end
      end
      ST_WAIT: begin
        // gate low halts only at a boundary
        if (s.trig_mode == TRG_GATED && !gate_hi && (!s.list_pace || s.idx == 4'h0)) begin
          n.st = ST_ARM;
        // external edge or internal timer, never both
        end else if (s.ext_sel ? pace_edge : itick) begin
          n.conv = 1'b1;
          // whole-list burst from the edge first entry at the edge
          if (s.ext_sel && s.list_pace && !last) begin
            n.st = ST_BURST;
            n.tmr = 16'(iv - 16'h0001);
          end
          // single channel per edge wrap at list end
          n.idx = last ? 4'h0 : s.idx + 4'h1;
        end
      end
      ST_BURST: begin
        if (itick) begin
          n.conv = 1'b1;
          n.idx = last ? 4'h0 : s.idx + 4'h1;
          if (last) begin
            n.st = ST_WAIT;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (n.conv) begin
      n.taken = s.taken + 32'h1;
      n.conv_chan = mem_rd;
      // shared clock pulses only with a real conversion
      n.sync_out = s.master;
      // stop on reaching the sample count
      if (s.count_lim != 32'h0 && n.taken >= s.count_lim) begin
        n.st = ST_IDLE;
      end
    end
    if (wr_go && s.awaddr == A_CTRL) begin
      if (s.wdata[C_STOP]) begin
        n.st = ST_IDLE;
      end else if (s.wdata[C_START]) begin
        n.st = ST_ARM;
        n.idx = 4'h0;
        n.taken = 32'h0;
      end
    end

    // output side trigger, single-shot or gated
    case (s.out_trig)
      TRG_SINGLE: n.orun = s.out_en && (s.orun || s.otrig_s[1]);
      TRG_GATED: n.orun = s.out_en && s.otrig_s[1];
      default: n.orun = s.out_en;
    endcase
    otick = s.out_ext ? (s.oclk_s[1] & ~s.oclk_d) : (s.otmr == 16'h0000);
    if (s.orun) begin
      n.otmr = (s.otmr == 16'h0000) ? 16'(s.oival - 16'h0001) : 16'(s.otmr - 16'h0001);
      n.out_upd = otick;
    end else begin
      n.otmr = 16'h0000;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      s <= '0;
      s.list_pace <= 1'b1;
      s.master <= 1'b1;
      s.ival <= IVAL_RST;
      s.oival <= IVAL_RST;
      s.len <= LEN_RST;
      s.trig_mode <= TRG_OFF;
      s.out_trig <= TRG_OFF;
      s.st <= ST_IDLE;
    end else begin
      s <= n;
    end
  end

  assign S_AXI_AWREADY = s.awrdy;
  assign S_AXI_WREADY = s.wrdy;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = s.arrdy;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RDATA = s.rdata;
  assign S_AXI_RRESP = s.rresp;
  assign SYNC_CLK_OUT = s.sync_out;
  assign OUT_UPDATE = s.out_upd;
  assign CONV.start = s.conv;
  assign CONV.chan = s.conv_chan;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);

  chk_no_early_conv: assert property (s.conv |-> $past(s.st) inside {ST_WAIT, ST_BURST})
    else $error("conversion outside a running state");
  chk_edge_starts_conv: assert property (s.st == ST_WAIT && s.ext_sel && pace_edge
    && s.trig_mode != TRG_GATED |=> s.conv)
    else $error("pacing edge did not convert");
  chk_burst_spacing: assert property (s.st == ST_BURST && itick |=> s.conv)
    else $error("burst entry missed its interval");
  chk_single_wrap: assert property (s.conv && $past(last) |-> s.idx == 4'h0)
    else $error("list index did not wrap");
  chk_gate_boundary: assert property (s.st == ST_ARM && $past(s.st) == ST_WAIT
    |-> $past(!s.list_pace || s.idx == 4'h0))
    else $error("gated stop inside a list");
  chk_no_tail_clock: assert property (s.sync_out |-> s.conv && s.master)
    else $error("shared clock without conversion");
  chk_internal_pace: assert property (s.conv && $past(s.st) == ST_WAIT && !$past(s.ext_sel)
    |-> $past(s.tmr) == 16'h0000)
    else $error("timer pacing fired early");
  chk_out_edge: assert property (s.out_upd && $past(s.out_ext)
    |-> $past(s.oclk_s[1] && !s.oclk_d))
    else $error("output update without rising edge");
  chk_single_shot: assert property (s.st == ST_ARM && s.trig_mode == TRG_SINGLE && !gate_hi
    |=> s.st inside {ST_ARM, ST_IDLE})
    else $error("single-shot left before trigger");

  cov_burst: cover property (s.st == ST_WAIT ##1 s.st == ST_BURST);
  cov_wrap: cover property (s.conv && s.idx == 4'h0 && !s.list_pace);
  cov_gate_stop: cover property (s.st == ST_WAIT ##1 s.st == ST_ARM);
  cov_period_err: cover property ($rose(s.perr));
endmodule

/* sct_pkg.sv */
// shared constants, register map and types of the sample clock trigger sequencer
// assumes a 25 MHz system clock and an AXI4-Lite register bus
// Overview of operation
// - react to rising edges of pacing clocks
// - whole-list mode: edge converts entire list
// - single mode: edge converts next channel
// - list pacing select, whole-list by default
// - external pacing only when selected, else timer
// - first entry at edge, then interval spacing
// - no maximum period, no edge timeout
// - single mode wraps to first entry
// - sample readable in its own cycle
// - no trailing clock after stop
// - slave role with flush-dependent units
// - master or slave clock role supported
// - dedicated trigger input starts, stops sampling
// - no samples before trigger event
// - input and output triggers: single-shot, gated
// - internal timers pace input and output
// - single-shot waits trigger, input side runs to count
// - gated runs while trigger high
// - trigger select: single-shot, gated, disabled default
// - gated stop only at list/channel boundaries
package sct_pkg;
  localparam int CLK_NS = 40;
  localparam int SYNC_MARGIN_NS = 200;
  localparam int SYNC_MARGIN_CYC = (SYNC_MARGIN_NS + CLK_NS - 1) / CLK_NS;
  // per-gain minimum sample times, gain codes 0..3 = 1, 4, 10, 40
  localparam int MIN_G1_NS = 4000;
  localparam int MIN_G4_NS = 10000;
  localparam int MIN_G10_NS = 10000;
  localparam int MIN_G40_NS = 50000;
  localparam int MIN_G1_CYC = (MIN_G1_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_G4_CYC = (MIN_G4_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_G10_CYC = (MIN_G10_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_G40_CYC = (MIN_G40_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_IVAL = 8'h04;
  localparam logic [7:0] A_LEN = 8'h08;
  localparam logic [7:0] A_COUNT = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_SAMPLE = 8'h14;
  localparam logic [7:0] A_TAKEN = 8'h18;
  localparam logic [7:0] A_OIVAL = 8'h1C;
  localparam logic [7:0] A_LIST = 8'h40;
  // control and status register fields
  localparam int C_START = 0;
  localparam int C_STOP = 1;
  localparam int C_LIST = 2;
  localparam int C_EXT = 3;
  localparam int C_TRIG = 4;
  localparam int C_MASTER = 6;
  localparam int C_OEN = 7;
  localparam int C_OEXT = 8;
  localparam int C_OTRIG = 9;
  localparam int C_GAIN = 11;
  localparam int S_PERR = 8;
  localparam logic [15:0] IVAL_RST = 16'h0064;
  localparam logic [4:0] LEN_RST = 5'h01;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {TRG_OFF = 2'h0, TRG_SINGLE = 2'h1, TRG_GATED = 2'h2} sct_trig_t;
  typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_ARM = 4'h2, ST_WAIT = 4'h4, ST_BURST = 4'h8} sct_st_t;
  typedef struct packed {
    logic start;
    logic [7:0] chan;
  } sct_conv_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sct_adc_t;
  typedef struct packed {
    logic aw_got, w_got, awrdy, wrdy, bvalid, arrdy, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] awaddr;
    logic [31:0] wdata, rdata;
    logic list_pace, ext_sel, master, out_en, out_ext;
    sct_trig_t trig_mode, out_trig;
    logic [1:0] gain;
    logic [15:0] ival, oival;
    logic [4:0] len;
    logic [31:0] count_lim, taken;
    logic [15:0] sample;
    logic [7:0] sample_chan;
    logic [1:0] eclk_s, sclk_s, trig_s, oclk_s, otrig_s;
    logic pace_d, oclk_d;
    sct_st_t st;
    logic [3:0] idx;
    logic [15:0] tmr, gap, otmr;
    logic perr, conv, sync_out, orun, out_upd;
    logic [7:0] conv_chan;
  } sct_state_t;
endpackage

/* sct_chan_mem.sv */
// channel list memory: one write port, one registered read port
// assumes both ports run on the sequencer clock
`timescale 1ns/1ns
module sct_chan_mem import sct_pkg::*; #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array; list entries are written before a start
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* sct_ext_src.sv */
// partner model: external pacing clock source and trigger hardware
// assumes the sequencer samples all five lines on its own clock, unrelated in phase
`timescale 1ns/1ns
module sct_ext_src (
  output logic EXT_CLK,
  output logic SYNC_CLK,
  output logic OUT_CLK,
  output logic TRIG,
  output logic OUT_TRIG
);
  initial begin
    EXT_CLK = 1'b0;
    SYNC_CLK = 1'b0;
    OUT_CLK = 1'b0;
    TRIG = 1'b0;
    OUT_TRIG = 1'b0;
  end
  // line select: 0 input pacing clock, 1 shared clock from a master unit, else output clock
  task automatic level(input int sel, input logic v);
    case (sel)
      0: EXT_CLK = v;
      1: SYNC_CLK = v;
      default: OUT_CLK = v;
    endcase
  endtask
  ////////////////////////////////////////////////////////////
  // caller picks low time so period covers interval plus margin
  // clock rests low between frames; odd offset keeps edges off the system clock phase
  task automatic edges_on(input int sel, input int n, input int low_ns);
    repeat (n) begin
      #37 level(sel, 1'b1);
      #160 level(sel, 1'b0);
      #(low_ns);
    end
  endtask
  task automatic edges(input int n, input int low_ns);
    edges_on(0, n, low_ns);
  endtask
  // trigger level from outside detection hardware
  task automatic trig(input logic v);
    #53 TRIG = v;
  endtask
  task automatic otrig(input logic v);
    #53 OUT_TRIG = v;
  endtask
endmodule

/* sct_seq_tb.sv */
// self-checking bench of the sequencer: bus master, converter stub, conversion monitor
// assumes sct_ext_src drives the pacing clock and trigger pins
`timescale 1ns/1ns
module sct_seq_tb import sct_pkg::*; ;
  localparam int IV = MIN_G1_CYC;
  logic mclk, rst_n, awv, wv, br, arv, rr, awr, wr, bv, arr, rv, sync_o, ext_clk, trig, free;
  logic sclk, oclk, otrig, out_u;
  logic [7:0] awa, ara, lf;
  logic [31:0] wd, rd;
  logic [1:0] bresp, rresp;
  logic [15:0] e, dat;
  logic [15:0] eq[$];
  logic [7:0] lst[3];
  sct_conv_t conv;
  sct_adc_t adc;
  int bad_count, num_checks, cyc, gap, fn, nconv, nsync, n0, nupd;

  sct_seq #(.LIST_DEPTH(16)) DUT (
    .MCLK(mclk), .NRST(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .EXT_CLK_IN(ext_clk),
    .SYNC_CLK_IN(sclk), .SYNC_CLK_OUT(sync_o), .TRIG_IN(trig), .EXT_CLK_OUT(oclk), .TRIG_OUT(otrig),
    .OUT_UPDATE(out_u), .CONV(conv), .ADC(adc)
  );
  sct_ext_src src (.EXT_CLK(ext_clk), .SYNC_CLK(sclk), .OUT_CLK(oclk), .TRIG(trig), .OUT_TRIG(otrig));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  function automatic logic [31:0] cw(logic st, logic lp, logic ex, logic [1:0] tg);
    cw = 32'h0000_0000;
    cw[C_START] = st;
    cw[C_LIST] = lp;
    cw[C_EXT] = ex;
    cw[C_TRIG +: 2] = tg;
    cw[C_MASTER] = 1'b1;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // the global timeout bounds this wait
  task automatic wq();
    while (eq.size() != 0) @(posedge mclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    // start one edge on, so a back-to-back call never drives a signal twice in one step
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge mclk);
      if (awv && awr === 1'b1) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr === 1'b1) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge mclk);
    chk("bresp", 32'(bresp), 32'(er));
    br <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m, input logic [1:0] er);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge mclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge mclk); while (rv !== 1'b1);
    chk("rdata", rd & m, ex & m);
    chk("rresp", 32'(rresp), 32'(er));
    rr <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  // conversion monitor: each start takes the oldest note off the queue, or while free is set is checked against the list order
  always @(posedge mclk) begin
    gap++;
    if (sync_o === 1'b1) nsync++;
    if (out_u === 1'b1) nupd++;
    if (rst_n && conv.start === 1'b1) begin
      nconv++;
      if (free) begin
        chk("gated chan", 32'(conv.chan), 32'(lst[fn % 3]));
        fn++;
      end else if (eq.size() == 0) begin
        chk("stray conversion", 32'h1, 32'h0);
      end else begin
        e = eq.pop_front();
        chk("chan", 32'(conv.chan), 32'(e[7:0]));
        if (e[15:8] != 8'h00) chk("spacing", 32'(gap), 32'(e[15:8]));
      end
      gap = 0;
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_n, awv, wv, br, arv, rr, free} = 7'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0000_0000;
    adc = '0;
    lf = 8'h4E;
    for (int i = 0; i < 3; i++) lst[i] = lfsr();
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    idle(2);
    axr(A_CTRL, cw(1'b0, 1'b1, 1'b0, 2'h0), 32'hFFFF_FFFF, RESP_OK);
    axr(A_IVAL, 32'(IVAL_RST), 32'hFFFF_FFFF, RESP_OK);
    axr(A_LEN, 32'(LEN_RST), 32'hFFFF_FFFF, RESP_OK);
    // unmapped and write-only places answer with an error
    axr(8'h20, 32'h0000_0000, 32'hFFFF_FFFF, RESP_ERR);
    axw(8'h20, 32'h0000_00A5, RESP_ERR);
    axr(A_LIST, 32'h0000_0000, 32'hFFFF_FFFF, RESP_ERR);
    for (int i = 0; i < 3; i++) axw(A_LIST + 8'(4 * i), 32'(lst[i]), RESP_OK);
    axw(A_LEN, 32'h0000_0003, RESP_OK);
    axw(A_IVAL, 32'(IV), RESP_OK);
    // one channel per edge, wrap, long pause accepted
    for (int k = 0; k < 4; k++) eq.push_back({8'h00, lst[k % 3]});
    axw(A_CTRL, cw(1'b1, 1'b0, 1'b1, 2'h0), RESP_OK);
    src.edges(3, 4400);
    idle(2000);
    src.edges(1, 4400);
    wq();
    axw(A_CTRL, cw(1'b0, 1'b0, 1'b1, 2'h0) | (32'h1 << C_STOP), RESP_OK);
    src.edges(2, 4400);
    idle(20);
    // whole list per edge at interval spacing
    for (int k = 0; k < 6; k++) eq.push_back({((k % 3) == 0 ? 8'h00 : 8'(IV)), lst[k % 3]});
    axw(A_CTRL, cw(1'b1, 1'b1, 1'b1, 2'h0), RESP_OK);
    src.edges(2, 12400);
    wq();
    axw(A_CTRL, cw(1'b0, 1'b1, 1'b1, 2'h0) | (32'h1 << C_STOP), RESP_OK);
    // internal timer, single-shot waits, stops at count
    axw(A_COUNT, 32'h0000_0003, RESP_OK);
    axw(A_CTRL, cw(1'b1, 1'b1, 1'b0, 2'h1), RESP_OK);
    idle(300);
    for (int k = 0; k < 3; k++) eq.push_back({(k == 0 ? 8'h00 : 8'(IV)), lst[k]});
    src.trig(1'b1);
    wq();
    idle(300);
    src.trig(1'b0);
    // gated runs while high, halts only at list ends
    axw(A_COUNT, 32'h0000_0000, RESP_OK);
    free = 1'b1;
    axw(A_CTRL, cw(1'b1, 1'b1, 1'b0, 2'h2), RESP_OK);
    src.trig(1'b1);
    idle(450);
    src.trig(1'b0);
    idle(400);
    chk("gated halt", 32'(fn >= 3 && fn % 3 == 0), 32'h1);
    n0 = fn;
    src.trig(1'b1);
    idle(150);
    src.trig(1'b0);
    idle(400);
    chk("gated restart", 32'(fn > n0 && fn % 3 == 0), 32'h1);
    free = 1'b0;
    axw(A_CTRL, cw(1'b0, 1'b1, 1'b0, 2'h0) | (32'h1 << C_STOP), RESP_OK);
    // slave paces from the shared clock only and drives no shared clock
    axw(A_CTRL, cw(1'b1, 1'b0, 1'b1, 2'h0) & ~(32'h1 << C_MASTER), RESP_OK);
    src.edges(1, 400);
    idle(20);
    eq.push_back({8'h00, lst[0]});
    src.edges_on(1, 1, 400);
    wq();
    axw(A_CTRL, cw(1'b0, 1'b0, 1'b1, 2'h0) | (32'h1 << C_STOP), RESP_OK);
    // gated output updates once per rising output clock edge, none while gated off
    axw(A_CTRL, (32'h1 << C_OEN) | (32'h1 << C_OEXT) | (32'h2 << C_OTRIG), RESP_OK);
    n0 = nupd;
    src.edges_on(2, 2, 400);
    idle(4);
    chk("upd gated off", 32'(nupd - n0), 32'h0);
    src.otrig(1'b1);
    idle(4);
    src.edges_on(2, 3, 400);
    idle(10);
    chk("upd per edge", 32'(nupd - n0), 32'h3);
    src.otrig(1'b0);
    // converter result readable right after capture
    for (int k = 0; k < 2; k++) begin
      dat = {lfsr(), lfsr()};
      adc <= '{1'b1, dat};
      @(posedge mclk);
      adc.valid <= 1'b0;
      axr(A_SAMPLE, 32'(dat), 32'h0000_FFFF, RESP_OK);
    end
    chk("sync pulses", 32'(nsync), 32'(nconv - 1));
    end_of_test();
  end
endmodule
